// [rtl/bdd_regs.sv]
/*
  Diagnostic and socket DMA configuration registers of a dual-socket
  card bridge, with the controls they steer.
  Assumes the host presents one configuration cycle per clock on the
  cfg_* port, byte addressed at dword offsets, with byte enables and function number.
*/
`timescale 1ns/1ps
module bdd_regs
  import bdd_pkg::*;
#(
  parameter int DISCARD_LONG_CLKS = BDD_DISCARD_LONG_CLKS
)(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic cfg_func,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  input wire logic [31:0] id_value,
  input wire logic [1:0] exca_803_b4,
  input wire logic [1:0][3:0] exca_805_hi,
  input wire logic [1:0] csc_event,
  output logic [1:0] csc_route_pci,
  output logic [1:0] csc_irq,
  input wire logic [1:0] card_spkr,
  input wire logic [1:0] card_iois16,
  input wire logic [1:0] card_inpack,
  output logic [1:0] card_dma_request,
  output logic delayed_txn_off,
  output logic [6:0] retry_limit,
  input wire logic dt_pending_host,
  input wire logic dt_pending_card,
  output logic discard_host,
  output logic discard_card
);

  ////////////////////////////////////////////////////////////////////////
  // Reset release
  logic rst_meta_reg, rst_n;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register storage
  logic [7:0] diag_glob_reg, diag_glob_next;
  logic [1:0][7:0] diag_loc_reg, diag_loc_next;
  logic [1:0][1:0] dma0_reg, dma0_next;
  logic [1:0][31:0] dma1_reg, dma1_next;
  logic [31:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;
  logic [1:0][7:0] diag_view;

  // Global bits come from the shared copy, the rest per function
  function automatic logic [7:0] bdd_diag_of(
    input logic [7:0] glob,
    input logic [7:0] loc
  );
    return (glob & BDD_DIAG_GLOBAL_MASK) | (loc & ~BDD_DIAG_GLOBAL_MASK);
  endfunction

  always_comb
  begin
    for (int s = 0; s < 2; s++)
    begin
      diag_view[s] = bdd_diag_of(diag_glob_reg, diag_loc_reg[s]);
    end
  end

  always_comb
  begin
    diag_glob_next = diag_glob_reg;
    diag_loc_next = diag_loc_reg;
    dma0_next = dma0_reg;
    dma1_next = dma1_reg;
    rvalid_next = cfg_rd;
    rdata_next = rdata_reg;
    if (cfg_wr)
    begin
      if (cfg_addr == BDD_DIAG_DW_OFF && cfg_be[BDD_DIAG_LANE])
      begin
        // Either function may write the shared bits; software keeps to 0
        diag_glob_next = cfg_wdata[BDD_DIAG_LANE*8 +: 8];
        diag_loc_next[cfg_func] = cfg_wdata[BDD_DIAG_LANE*8 +: 8];
      end
      if (cfg_addr == BDD_DMA0_OFF && cfg_be[0])
      begin
        dma0_next[cfg_func] = cfg_wdata[1:0];
      end
      if (cfg_addr == BDD_DMA1_OFF)
      begin
        dma1_next[cfg_func] = bdd_merge(dma1_reg[cfg_func], cfg_wdata,
                                        cfg_be) & BDD_DMA1_RW_MASK;
      end
    end
    if (cfg_rd)
    begin
      case (cfg_addr)
        BDD_ID_OFF:
        begin
          rdata_next = diag_view[cfg_func][BDD_ID_READ_MASK_BIT]
                       ? 32'hFFFFFFFF : id_value;
        end
        BDD_DIAG_DW_OFF:
        begin
          rdata_next = {diag_view[cfg_func], 24'h000000};
        end
        BDD_DMA0_OFF:
        begin
          rdata_next = {30'h00000000, dma0_reg[cfg_func]};
        end
        BDD_DMA1_OFF:
        begin
          rdata_next = dma1_reg[cfg_func] & BDD_DMA1_RW_MASK;
        end
        default:
        begin
          rdata_next = 32'h00000000;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      diag_glob_reg <= BDD_DIAG_RESET;
      diag_loc_reg <= {BDD_DIAG_RESET, BDD_DIAG_RESET};
      dma0_reg <= {BDD_DMA0_RESET[1:0], BDD_DMA0_RESET[1:0]};
      dma1_reg <= {BDD_DMA1_RESET, BDD_DMA1_RESET};
      rdata_reg <= 32'h00000000;
      rvalid_reg <= 1'b0;
    end
    else
    begin
      diag_glob_reg <= diag_glob_next;
      diag_loc_reg <= diag_loc_next;
      dma0_reg <= dma0_next;
      dma1_reg <= dma1_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign cfg_rdata = rdata_reg;
  assign cfg_rvalid = rvalid_reg;

  ////////////////////////////////////////////////////////////////////////
  // Steered controls
  logic [1:0] route_now;
  logic [1:0] route_reg, route_next;
  logic [1:0] irq_reg, irq_next;
  logic [1:0] card_dma_request_reg, card_dma_request_next;
  logic dt_off_reg, dt_off_next;
  logic [6:0] retry_reg, retry_next;

  always_comb
  begin
    for (int s = 0; s < 2; s++)
    begin
      if (diag_view[s][BDD_ROUTE_SEL_BIT])
      begin
        route_now[s] = (exca_805_hi[s] == 4'h0);
      end
      else
      begin
        route_now[s] = exca_803_b4[s];
      end
    end
  end

  always_comb
  begin
    route_next = route_now;
    irq_next = csc_event & route_now;
    for (int s = 0; s < 2; s++)
    begin
      case (bdd_card_dma_request_type'(dma0_reg[s]))
        BDD_CARD_DMA_REQUEST_SPKR: card_dma_request_next[s] = card_spkr[s];
        BDD_CARD_DMA_REQUEST_IOIS16: card_dma_request_next[s] = card_iois16[s];
        BDD_CARD_DMA_REQUEST_INPACK: card_dma_request_next[s] = card_inpack[s];
        default: card_dma_request_next[s] = 1'b0;
      endcase
    end
    dt_off_next = diag_glob_reg[BDD_DT_OFF_BIT];
    retry_next = diag_glob_reg[BDD_RETRY_WINDOW_LONGER_BIT]
                 ? BDD_RETRY_LONG_CLKS : BDD_RETRY_SHORT_CLKS;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      route_reg <= 2'h0;
      irq_reg <= 2'h0;
      card_dma_request_reg <= 2'h0;
      dt_off_reg <= 1'b0;
      retry_reg <= BDD_RETRY_SHORT_CLKS;
    end
    else
    begin
      route_reg <= route_next;
      irq_reg <= irq_next;
      card_dma_request_reg <= card_dma_request_next;
      dt_off_reg <= dt_off_next;
      retry_reg <= retry_next;
    end
  end

  // Status_irq_nonclocked_enable path skips the flop so a stopped clock cannot hold it back
  always_comb
  begin
    for (int s = 0; s < 2; s++)
    begin
      csc_irq[s] = diag_view[s][BDD_STATUS_IRQ_NONCLOCKED_ENABLE_BIT]
                   ? (csc_event[s] & route_now[s]) : irq_reg[s];
    end
  end

  assign csc_route_pci = route_reg;
  assign card_dma_request = card_dma_request_reg;
  assign delayed_txn_off = dt_off_reg;
  assign retry_limit = retry_reg;

  ////////////////////////////////////////////////////////////////////////
  // Discard timers; held off entirely while delayed handling is off
  bdd_timer_if host_tmr();
  bdd_timer_if card_tmr();

  assign host_tmr.sel_short = diag_glob_reg[BDD_HOST_DISC_BIT];
  assign host_tmr.pending = dt_pending_host & ~dt_off_reg;
  assign card_tmr.sel_short = diag_glob_reg[BDD_CARD_DISC_BIT];
  assign card_tmr.pending = dt_pending_card & ~dt_off_reg;
  assign discard_host = host_tmr.expire;
  assign discard_card = card_tmr.expire;

  bdd_discard_timer #(.LONG_CLKS(DISCARD_LONG_CLKS)) u_host_timer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .tif(host_tmr)
  );

  bdd_discard_timer #(.LONG_CLKS(DISCARD_LONG_CLKS)) u_card_timer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .tif(card_tmr)
  );

endmodule // bdd_regs

// [rtl/bdd_pkg.sv]
/*
  Constants, field layout and helpers for the bridge diagnostic and
  socket DMA select configuration registers.
  Assumes byte-addressed configuration space, 32-bit dword access.
*/
package bdd_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Offsets
  localparam logic [7:0] BDD_ID_OFF = 8'h00;
  localparam logic [7:0] BDD_DIAG_DW_OFF = 8'h90;
  localparam logic [7:0] BDD_DIAG_OFF = 8'h93;
  localparam logic [7:0] BDD_DMA0_OFF = 8'h94;
  localparam logic [7:0] BDD_DMA1_OFF = 8'h98;
  localparam int BDD_DIAG_LANE = 3;

  ////////////////////////////////////////////////////////////////////////
  // Diagnostic register fields
  localparam int BDD_ID_READ_MASK_BIT = 7;
  localparam int BDD_SPARE_BIT = 6;
  localparam int BDD_ROUTE_SEL_BIT = 5;
  localparam int BDD_DT_OFF_BIT = 4;
  localparam int BDD_RETRY_WINDOW_LONGER_BIT = 3;
  localparam int BDD_CARD_DISC_BIT = 2;
  localparam int BDD_HOST_DISC_BIT = 1;
  localparam int BDD_STATUS_IRQ_NONCLOCKED_ENABLE_BIT = 0;
  localparam logic [7:0] BDD_DIAG_RESET = 8'h61;
  localparam logic [7:0] BDD_DIAG_GLOBAL_MASK = 8'h9E;

  ////////////////////////////////////////////////////////////////////////
  // Socket DMA registers
  localparam logic [31:0] BDD_DMA0_RESET = 32'h00000000;
  localparam logic [31:0] BDD_DMA0_RW_MASK = 32'h00000003;
  localparam logic [31:0] BDD_DMA1_RESET = 32'h00000000;
  localparam logic [31:0] BDD_DMA1_RW_MASK = 32'h0000FFF7;

  typedef enum logic [1:0] {
    BDD_CARD_DMA_REQUEST_NONE = 2'h0,
    BDD_CARD_DMA_REQUEST_SPKR = 2'h1,
    BDD_CARD_DMA_REQUEST_IOIS16 = 2'h2,
    BDD_CARD_DMA_REQUEST_INPACK = 2'h3
  } bdd_card_dma_request_type;

  ////////////////////////////////////////////////////////////////////////
  // Timing, in clocks
  localparam logic [6:0] BDD_RETRY_SHORT_CLKS = 7'h10;
  localparam logic [6:0] BDD_RETRY_LONG_CLKS = 7'h40;
  localparam int BDD_DISCARD_SHORT_CLKS = 1024;
  localparam int BDD_DISCARD_LONG_CLKS = 32768;

  // Byte-enable merge of a write into a stored word
  function automatic logic [31:0] bdd_merge(
    input logic [31:0] old_val,
    input logic [31:0] wr_val,
    input logic [3:0] be
  );
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        res[i*8 +: 8] = wr_val[i*8 +: 8];
      end
    end
    return res;
  endfunction

endpackage

// [rtl/bdd_timer_if.sv]
/*
  Link between the register bank and one discard timer.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface bdd_timer_if;
  logic sel_short;
  logic pending;
  logic expire;
  modport ctrl (output sel_short, output pending, input expire);
  modport timer (input sel_short, input pending, output expire);
endinterface

// [rtl/bdd_discard_timer.sv]
/*
  Delayed-transaction discard timer: counts while a transaction is held
  and pulses expire once after the selected number of clocks.
  Assumes pending stays high while the delayed transaction is held.
*/
`timescale 1ns/1ps
module bdd_discard_timer
  import bdd_pkg::*;
#(
  parameter int LONG_CLKS = BDD_DISCARD_LONG_CLKS
)(
  input wire logic sys_clk,
  input wire logic rst_n,
  bdd_timer_if.timer tif
);

  typedef enum logic [1:0] {BDD_T_IDLE, BDD_T_COUNT, BDD_T_DONE}
    bdd_tstate_type;

  bdd_tstate_type state_reg, state_next;
  logic [15:0] count_reg, count_next;
  logic expire_reg, expire_next;
  logic [15:0] limit;

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    limit = tif.sel_short ? 16'(BDD_DISCARD_SHORT_CLKS - 1)
                          : 16'(LONG_CLKS - 1);
    state_next = state_reg;
    count_next = count_reg;
    expire_next = 1'b0;
    case (state_reg)
      BDD_T_IDLE:
      begin
        count_next = 16'h0000;
        if (tif.pending)
        begin
          state_next = BDD_T_COUNT;
        end
      end
      BDD_T_COUNT:
      begin
        if (!tif.pending)
        begin
          state_next = BDD_T_IDLE;
        end
        else if (count_reg >= limit)
        begin
          // Compare, not equality: select may shrink mid-count
          expire_next = 1'b1;
          state_next = BDD_T_DONE;
        end
        else
        begin
          count_next = count_reg + 16'h0001;
        end
      end
      BDD_T_DONE:
      begin
        if (!tif.pending)
        begin
          state_next = BDD_T_IDLE;
        end
      end
      default:
      begin
        state_next = BDD_T_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= BDD_T_IDLE;
      count_reg <= 16'h0000;
      expire_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      count_reg <= count_next;
      expire_reg <= expire_next;
    end
  end

  assign tif.expire = expire_reg;

endmodule // bdd_discard_timer

// [sim/bdd_regs_monitor.sv]
/*
  Port checker for bdd_regs, bound into every instance.
  Assumes one clock and the active-low rstn of the top module.
*/
`timescale 1ns/1ps
module bdd_regs_monitor
  import bdd_pkg::*;
#(
  parameter int DISCARD_LONG_CLKS = BDD_DISCARD_LONG_CLKS
)(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_rvalid,
  input wire logic [1:0] csc_event,
  input wire logic [1:0] csc_irq,
  input wire logic delayed_txn_off,
  input wire logic [6:0] retry_limit,
  input wire logic dt_pending_host,
  input wire logic dt_pending_card,
  input wire logic discard_host,
  input wire logic discard_card
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);
  logic diag_wr;
  assign diag_wr = cfg_wr && cfg_addr == 8'h90 && cfg_be[3];
  ////////////////////////////////////////
  property p_rd_ans;
    cfg_rd |=> cfg_rvalid;
  endproperty
  a_rd_ans: assert property (p_rd_ans)
    else $error("read not answered");
  property p_no_ans;
    !cfg_rd |=> !cfg_rvalid;
  endproperty
  a_no_ans: assert property (p_no_ans)
    else $error("answer without read");
  property p_diag_lanes;
    cfg_rd && cfg_addr == 8'h90 |=> cfg_rdata[23:0] == 24'h0;
  endproperty
  a_diag_lanes: assert property (p_diag_lanes)
    else $error("diag dword low bytes not zero");
  property p_dma0;
    cfg_rd && cfg_addr == 8'h94 |=> cfg_rdata[31:2] == 30'h0;
  endproperty
  a_dma0: assert property (p_dma0)
    else $error("dma select upper bits not zero");
  property p_dma1;
    cfg_rd && cfg_addr == 8'h98 |=> !cfg_rdata[3] && !(|cfg_rdata[31:16]);
  endproperty
  a_dma1: assert property (p_dma1)
    else $error("dma base read-only bits not zero");
  // Two edges: the stored bit, then its registered copy
  property p_retry;
    diag_wr |=> ##1 retry_limit == ($past(cfg_wdata[27], 2) ? 7'h40 : 7'h10);
  endproperty
  a_retry: assert property (p_retry)
    else $error("retry limit wrong");
  property p_dt_off;
    diag_wr |=> ##1 delayed_txn_off == $past(cfg_wdata[28], 2);
  endproperty
  a_dt_off: assert property (p_dt_off)
    else $error("delayed transaction disable wrong");
  property p_disc_blk;
    delayed_txn_off && $past(delayed_txn_off, 2) |->
      !discard_host && !discard_card;
  endproperty
  a_disc_blk: assert property (p_disc_blk)
    else $error("discard while disabled");
  property p_disc_one;
    discard_host |=> !discard_host;
  endproperty
  a_disc_one: assert property (p_disc_one)
    else $error("host discard longer than one cycle");
  property p_disc_early;
    $rose(dt_pending_card) |=> !discard_card [*8];
  endproperty
  a_disc_early: assert property (p_disc_early)
    else $error("card discard too early");
  property p_csc;
    csc_irq[0] |-> csc_event[0] || $past(csc_event[0]);
  endproperty
  a_csc: assert property (p_csc)
    else $error("status interrupt without event");
  ////////////////////////////////////////
  // Held host run length; saturates so a long hold cannot wrap to zero
  logic [15:0] host_run;
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      host_run <= 16'h0000;
    end
    else if (!dt_pending_host)
    begin
      host_run <= 16'h0000;
    end
    else if (host_run != 16'hFFFF)
    begin
      host_run <= host_run + 16'h0001;
    end
  end
  // Select is not visible here, so only the shorter timeout is bounded
  localparam int MIN_CLKS = (DISCARD_LONG_CLKS < BDD_DISCARD_SHORT_CLKS)
    ? DISCARD_LONG_CLKS : BDD_DISCARD_SHORT_CLKS;
  property p_disc_min;
    discard_host |-> host_run > 16'(MIN_CLKS);
  endproperty
  a_disc_min: assert property (p_disc_min)
    else $error("host discard before timeout");
  c_diag_wr: cover property (diag_wr);
  c_disc_h: cover property (discard_host);
  c_disc_c: cover property (discard_card);
endmodule // bdd_regs_monitor

bind bdd_regs bdd_regs_monitor #(.DISCARD_LONG_CLKS(DISCARD_LONG_CLKS))
  i_mon (.sys_clk(sys_clk), .rstn(rstn), .cfg_addr(cfg_addr),
  .cfg_be(cfg_be), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
  .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
  .csc_event(csc_event), .csc_irq(csc_irq),
  .delayed_txn_off(delayed_txn_off), .retry_limit(retry_limit),
  .dt_pending_host(dt_pending_host),
  .dt_pending_card(dt_pending_card), .discard_host(discard_host),
  .discard_card(discard_card));

// [sim/bdd_host.sv]
/*
  Configuration host model: one strobed cycle per call of op.
  Assumes sys_clk from the bench; drives 1 ns after the edge.
*/
`timescale 1ns/1ps
module bdd_host (
  input wire logic sys_clk,
  output logic cfg_func,
  output logic [7:0] cfg_addr,
  output logic [3:0] cfg_be,
  output logic cfg_wr,
  output logic cfg_rd,
  output logic [31:0] cfg_wdata
);
  initial
  begin
    {cfg_func, cfg_addr, cfg_be, cfg_wr, cfg_rd, cfg_wdata} = '0;
  end
  // After the cycle the strobes are cleared and the other lines inverted so stale values are never trusted
  task automatic op(input logic w, input logic f, input logic [7:0] a,
    input logic [3:0] be, input logic [31:0] d);
    @(posedge sys_clk);
    #1;
    cfg_func = f;
    cfg_addr = a;
    cfg_be = be;
    cfg_wdata = d;
    cfg_wr = w;
    cfg_rd = !w;
    @(posedge sys_clk);
    #1;
    {cfg_wr, cfg_rd} = 2'h0;
    {cfg_func, cfg_addr, cfg_be, cfg_wdata} = ~{f, a, be, d};
  endtask
endmodule // bdd_host

// [sim/bridge_diag_and_dma_select_regs_bench.sv]
/*
  Self-checking bench for bdd_regs with a host model.
  Assumes a short long-discard count of 64 clocks.
*/
`timescale 1ns/1ps
module bridge_diag_and_dma_select_regs_bench;
  import bdd_pkg::*;
  logic sys_clk, rstn, cfg_func, cfg_wr, cfg_rd, cfg_rvalid;
  logic [7:0] cfg_addr;
  logic [3:0] cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata, id_value, r;
  logic [1:0] exca_803_b4, csc_event, csc_route_pci, csc_irq;
  logic [1:0][3:0] exca_805_hi;
  logic [1:0] card_spkr, card_iois16, card_inpack, card_dma_request;
  logic delayed_txn_off, dt_pending_host, dt_pending_card;
  logic discard_host, discard_card;
  logic [6:0] retry_limit;
  logic [31:0] exp_q[$];
  int num_errors = 0;
  int checks_done = 0;
  int n;
  integer seed = 12527;
  bdd_host i_host (.sys_clk(sys_clk), .cfg_func(cfg_func),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_wdata(cfg_wdata));
  bdd_regs #(.DISCARD_LONG_CLKS(64)) i_dut (.sys_clk(sys_clk),
    .rstn(rstn), .cfg_func(cfg_func), .cfg_addr(cfg_addr),
    .cfg_be(cfg_be), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid), .id_value(id_value),
    .exca_803_b4(exca_803_b4), .exca_805_hi(exca_805_hi),
    .csc_event(csc_event), .csc_route_pci(csc_route_pci),
    .csc_irq(csc_irq), .card_spkr(card_spkr), .card_iois16(card_iois16),
    .card_inpack(card_inpack), .card_dma_request(card_dma_request),
    .delayed_txn_off(delayed_txn_off), .retry_limit(retry_limit),
    .dt_pending_host(dt_pending_host), .dt_pending_card(dt_pending_card),
    .discard_host(discard_host), .discard_card(discard_card));
  ////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic f, input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    i_host.op(1'b0, f, a, 4'h0, 32'h0);
  endtask
  task automatic wdiag(input logic f, input logic [7:0] d);
    i_host.op(1'b1, f, 8'h90, 4'h8, {d, 24'h0});
  endtask
  task automatic settle;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  // Edges from pending to discard pulse, capped at 1100
  task automatic tmr(input logic card, input logic [7:0] dg);
    wdiag(1'b0, dg);
    settle;
    {dt_pending_card, dt_pending_host} = {card, !card};
    n = 0;
    do
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    while (!(card ? discard_card : discard_host) && n < 1100);
    {dt_pending_card, dt_pending_host} = 2'h0;
  endtask
  function automatic logic expd(input logic [1:0] sel, input int k);
    logic [3:0] v;
    v = {card_inpack[k], card_iois16[k], card_spkr[k], 1'b0};
    return v[sel];
  endfunction
  ////////////////////////////////////////
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(negedge sys_clk)
  begin
    if (cfg_rvalid === 1'b1)
    begin
      if (exp_q.size() > 0)
        chk(cfg_rdata, exp_q.pop_front());
      else
        chk(cfg_rvalid, 1'b0);
    end
  end
  initial
  begin
    repeat (100000) @(posedge sys_clk);
    num_errors++;
    tally_and_finish;
  end
  initial
  begin
    rstn = 1'b0;
    id_value = $random(seed);
    {exca_803_b4, exca_805_hi, csc_event} = '0;
    {card_spkr, card_iois16, card_inpack} = '0;
    {dt_pending_host, dt_pending_card} = 2'h0;
    repeat (12) @(posedge sys_clk);
    #1;
    rstn = 1'b1;
    repeat (3) @(posedge sys_clk);
    rd(0, 8'h90, 32'h61000000);
    rd(1, 8'h90, 32'h61000000);
    rd(0, 8'h94, 32'h0);
    rd(1, 8'h98, 32'h0);
    rd(0, 8'h00, id_value);
    rd(0, 8'h04, 32'h0);
    wdiag(0, 8'hE1);
    rd(1, 8'h00, 32'hFFFFFFFF);
    wdiag(0, 8'h61);
    rd(0, 8'h00, id_value);
    i_host.op(1, 0, 8'h94, 4'hF, 32'hFFFFFFFF);
    rd(0, 8'h94, 32'h3);
    i_host.op(1, 1, 8'h98, 4'hF, 32'hFFFFFFFF);
    rd(1, 8'h98, 32'h0000FFF7);
    wdiag(1, 8'h40);
    rd(1, 8'h90, 32'h40000000);
    rd(0, 8'h90, 32'h61000000);
    for (int i = 0; i < 8; i++)
    begin
      r = $random(seed);
      exca_805_hi[0] = r[3:0] & {4{r[4]}};
      exca_805_hi[1] = r[7:4];
      exca_803_b4 = r[9:8];
      settle;
      chk(csc_route_pci, {exca_803_b4[1], ~|exca_805_hi[0]});
    end
    for (int s = 0; s < 4; s++)
    begin
      i_host.op(1, 0, 8'h94, 4'h1, s);
      i_host.op(1, 1, 8'h94, 4'h1, 3 - s);
      r = $random(seed);
      {card_spkr, card_iois16, card_inpack} = r[5:0];
      settle;
      chk(card_dma_request, {expd(3 - s, 1), expd(s, 0)});
    end
    exca_805_hi[0] = 4'h0;
    settle;
    csc_event[0] = 1'b1;
    #1;
    chk(csc_irq[0], 1'b1);
    csc_event[0] = 1'b0;
    wdiag(0, 8'h60);
    exca_803_b4[1] = 1'b1;
    settle;
    csc_event = 2'h3;
    #1;
    chk(csc_irq, 2'h0);
    @(posedge sys_clk);
    #1;
    chk(csc_irq, 2'h3);
    csc_event = 2'h0;
    tmr(0, 8'h61);
    chk(n >= 63 && n <= 67, 1);
    tmr(0, 8'h63);
    chk(n >= 1023 && n <= 1027, 1);
    tmr(1, 8'h69);
    chk(n >= 63 && n <= 67, 1);
    chk(retry_limit, 7'h40);
    tmr(1, 8'h71);
    chk(n, 1100);
    chk(delayed_txn_off, 1'b1);
    settle;
    chk(exp_q.size(), 0);
    tally_and_finish;
  end
endmodule // bridge_diag_and_dma_select_regs_bench
